// [uflc_pkg.sv]
// shared constants, register map and format helpers for the line format block
package uflc_pkg;
  // register byte offsets, one 32-bit word each
  localparam logic [7:0] OFS_DATA = 8'h00; // tx/rx data, divisor low while access select set
  localparam logic [7:0] OFS_DIV_HI = 8'h04; // divisor high, only while access select set
  localparam logic [7:0] OFS_EFR = 8'h08; // enhanced feature byte, only while access select set
  localparam logic [7:0] OFS_LFC = 8'h0c; // line_format_control
  localparam logic [7:0] OFS_STAT = 8'h10; // status
  // line_format_control field positions
  localparam int LFC_DLAB = 7;
  localparam int LFC_BRK = 6;
  localparam int LFC_STICK = 5;
  localparam int LFC_EVEN = 4;
  localparam int LFC_PEN = 3;
  localparam int LFC_STOP = 2;
  localparam int LFC_WL_HI = 1;
  localparam int LFC_WL_LO = 0;
  // status field positions
  localparam int ST_RX_RDY = 0;
  localparam int ST_THR_EMPTY = 1;
  localparam int ST_TX_IDLE = 2;
  localparam int ST_PERR = 3;
  localparam int ST_FERR = 4;
  // reset values
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0] EFR_RST = 8'h00;
  // oversampling ticks per bit and stop lengths
  localparam logic [5:0] BIT_TICKS = 6'h10;
  localparam logic [5:0] HALF_TICKS = 6'h08;
  localparam logic [5:0] STOP15_TICKS = 6'h18;
  localparam logic [5:0] STOP2_TICKS = 6'h20;

  // keep only the programmed number of data bits
  function automatic logic [7:0] uflc_mask(input logic [7:0] d, input logic [1:0] wl);
    return d & (8'hff >> (2'd3 - wl));
  endfunction

  // parity bit for a character: forced, odd or even
  function automatic logic uflc_par(input logic [7:0] d, input logic [1:0] wl, input logic even,
                                    input logic stick);
    if (stick) return ~even;
    return even ? ^uflc_mask(d, wl) : ~^uflc_mask(d, wl);
  endfunction

  // stop length in ticks from select bit and word length
  function automatic logic [5:0] uflc_stop_ticks(input logic sel, input logic [1:0] wl);
    if (!sel) return BIT_TICKS;
    if (wl == 2'b00) return STOP15_TICKS;
    return STOP2_TICKS;
  endfunction

  // index of the last data bit
  function automatic logic [2:0] uflc_last_bit(input logic [1:0] wl);
    return 3'd4 + {1'b0, wl};
  endfunction
endpackage

// [uflc_fmt_if.sv]
// character format and tick carried from the register file to the shifters
`timescale 1ns/1ps
interface uflc_fmt_if;
  logic [1:0] wlen; // word length select
  logic stop_sel; // stop bit select
  logic par_en; // parity enable
  logic even_sel; // even parity select
  logic stick; // stick parity
  logic tick; // one-cycle 16x oversample enable
  modport ctl(output wlen, stop_sel, par_en, even_sel, stick, tick);
  modport sh(input wlen, stop_sel, par_en, even_sel, stick, tick);
endinterface

// [uflc_tx.sv]
// transmit shifter: start, data, optional parity, stop
`timescale 1ns/1ps
module uflc_tx import uflc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  uflc_fmt_if.sh fmt,
  input wire logic start_i,
  input wire logic [7:0] data_i,
  output logic ready_o,
  output logic line_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uflc_tx_st_e;
  uflc_tx_st_e st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt; // ticks within the bit
  logic [2:0] bit_r, bit_nxt; // data bit index
  logic [7:0] sh_r, sh_nxt;
  logic par_r, par_nxt, pen_r, pen_nxt, stp_r, stp_nxt, line_r, line_nxt;
  logic [1:0] wl_r, wl_nxt;
  logic end_bit;

  // format is latched at start so a write mid-character cannot tear the frame
  always_comb begin
    end_bit = fmt.tick && (cnt_r == BIT_TICKS - 6'h01);
    st_nxt = st_r;
    cnt_nxt = fmt.tick ? cnt_r + 6'h01 : cnt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    par_nxt = par_r;
    pen_nxt = pen_r;
    wl_nxt = wl_r;
    stp_nxt = stp_r;
    line_nxt = 1'b1;
    unique case (st_r)
      TX_IDLE: begin
        cnt_nxt = 6'h00;
        if (start_i) begin
          sh_nxt = data_i;
          par_nxt = uflc_par(data_i, fmt.wlen, fmt.even_sel, fmt.stick);
          pen_nxt = fmt.par_en;
          wl_nxt = fmt.wlen;
          stp_nxt = fmt.stop_sel;
          st_nxt = TX_START;
        end
      end
      TX_START: begin
        line_nxt = 1'b0;
        if (end_bit) begin
          cnt_nxt = 6'h00;
          bit_nxt = 3'd0;
          st_nxt = TX_DATA;
        end
      end
      TX_DATA: begin
        line_nxt = sh_r[0];
        if (end_bit) begin
          cnt_nxt = 6'h00;
          sh_nxt = {1'b0, sh_r[7:1]};
          bit_nxt = bit_r + 3'd1;
          if (bit_r == uflc_last_bit(wl_r)) st_nxt = pen_r ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR: begin
        line_nxt = par_r;
        if (end_bit) begin
          cnt_nxt = 6'h00;
          st_nxt = TX_STOP;
        end
      end
      TX_STOP: begin
        if (fmt.tick && cnt_r == uflc_stop_ticks(stp_r, wl_r) - 6'h01) begin
          cnt_nxt = 6'h00;
          st_nxt = TX_IDLE;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= TX_IDLE;
      cnt_r <= 6'h00;
      bit_r <= 3'd0;
      sh_r <= 8'h00;
      {par_r, pen_r, stp_r, wl_r} <= 5'h00;
      line_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      {par_r, pen_r, stp_r, wl_r} <= {par_nxt, pen_nxt, stp_nxt, wl_nxt};
      line_r <= line_nxt;
    end
  end

  assign ready_o = (st_r == TX_IDLE);
  assign line_o = line_r;

  sequence s_load;
    st_r == TX_IDLE && start_i && fmt.par_en;
  endsequence
  property p_mark_par;
    @(posedge core_clk_i) disable iff (sys_rst_i) s_load ##0 (fmt.stick && !fmt.even_sel) |=> par_r;
  endproperty
  a_mark_par: assert property (p_mark_par) else $error("stick parity not forced to one");
  property p_space_par;
    @(posedge core_clk_i) disable iff (sys_rst_i) s_load ##0 (fmt.stick && fmt.even_sel) |=> !par_r;
  endproperty
  a_space_par: assert property (p_space_par) else $error("stick parity not forced to zero");
  property p_calc_par;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      s_load ##0 !fmt.stick |=> (^{uflc_mask(sh_r, wl_r), par_r}) == !$past(fmt.even_sel);
  endproperty
  a_calc_par: assert property (p_calc_par) else $error("computed parity wrong");
  property p_par_only_en;
    @(posedge core_clk_i) disable iff (sys_rst_i) st_r == TX_PAR |-> pen_r ##1 (line_r == par_r);
  endproperty
  a_par_only_en: assert property (p_par_only_en) else $error("parity slot without enable");
  // stop slot ends after one, one and a half or two bits of latched format
  property p_stop_ticks;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_r == TX_STOP && st_nxt == TX_IDLE) |->
        cnt_r == (stp_r ? ((wl_r == 2'b00) ? STOP15_TICKS : STOP2_TICKS) : BIT_TICKS) - 6'h01;
  endproperty
  a_stop_ticks: assert property (p_stop_ticks) else $error("stop length wrong");
  property p_data_len;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_r == TX_DATA && st_nxt != TX_DATA) |-> bit_r == uflc_last_bit(wl_r) ##1 bit_r == 3'd5 + {1'b0, wl_r};
  endproperty
  a_data_len: assert property (p_data_len) else $error("data bit count wrong");
endmodule // uflc_tx

// [uflc_rx.sv]
// receive shifter: start check, data, parity check, stop check
`timescale 1ns/1ps
module uflc_rx import uflc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  uflc_fmt_if.sh fmt,
  input wire logic rxd_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic perr_o,
  output logic ferr_o
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uflc_rx_st_e;
  uflc_rx_st_e st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, data_r, data_nxt;
  logic pe_r, pe_nxt, done_r, done_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt;
  logic mid;

  // samples at mid-bit; stop sampled once, so half stop bits are accepted
  always_comb begin
    mid = fmt.tick && (cnt_r == BIT_TICKS - 6'h01);
    st_nxt = st_r;
    cnt_nxt = fmt.tick ? cnt_r + 6'h01 : cnt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    data_nxt = data_r;
    pe_nxt = pe_r;
    done_nxt = 1'b0;
    perr_nxt = perr_r;
    ferr_nxt = ferr_r;
    unique case (st_r)
      RX_IDLE: begin
        cnt_nxt = 6'h00;
        if (!rxd_i) st_nxt = RX_START;
      end
      RX_START: begin
        if (fmt.tick && cnt_r == HALF_TICKS - 6'h01) begin
          cnt_nxt = 6'h00;
          bit_nxt = 3'd0;
          st_nxt = rxd_i ? RX_IDLE : RX_DATA; // false start rejected
        end
      end
      RX_DATA: begin
        if (mid) begin
          cnt_nxt = 6'h00;
          sh_nxt = {rxd_i, sh_r[7:1]};
          bit_nxt = bit_r + 3'd1;
          if (bit_r == uflc_last_bit(fmt.wlen)) st_nxt = fmt.par_en ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (mid) begin
          cnt_nxt = 6'h00;
          pe_nxt = rxd_i != uflc_par(sh_r >> (2'd3 - fmt.wlen), fmt.wlen, fmt.even_sel, fmt.stick);
          st_nxt = RX_STOP;
        end
      end
      RX_STOP: begin
        if (mid) begin
          done_nxt = 1'b1;
          data_nxt = sh_r >> (2'd3 - fmt.wlen);
          perr_nxt = pe_r && fmt.par_en;
          ferr_nxt = !rxd_i;
          pe_nxt = 1'b0;
          st_nxt = RX_IDLE;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= RX_IDLE;
      cnt_r <= 6'h00;
      bit_r <= 3'd0;
      sh_r <= 8'h00;
      data_r <= 8'h00;
      {pe_r, done_r, perr_r, ferr_r} <= 4'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      data_r <= data_nxt;
      {pe_r, done_r, perr_r, ferr_r} <= {pe_nxt, done_nxt, perr_nxt, ferr_nxt};
    end
  end

  assign done_o = done_r;
  assign data_o = data_r;
  assign perr_o = perr_r;
  assign ferr_o = ferr_r;
endmodule // uflc_rx

// [uflc_top.sv]
// line format control register file, Wishbone slave and serial line glue
`timescale 1ns/1ps
module uflc_top import uflc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_rx_i,
  output logic serial_tx_o
);
  // bus slave state
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  // register file
  logic [7:0] lfc_r, lfc_nxt; // line_format_control
  logic [15:0] div_r, div_nxt; // baud divisor
  logic [7:0] efr_r, efr_nxt; // enhanced feature byte, stored only
  logic [7:0] thr_r, thr_nxt; // transmit holding byte
  logic thr_full_r, thr_full_nxt;
  logic [7:0] rbr_r, rbr_nxt; // last received byte
  logic rx_rdy_r, rx_rdy_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt;
  // divider
  logic [15:0] tcnt_r, tcnt_nxt;
  logic tick_r, tick_nxt;
  // line
  logic rx_meta_r, rx_sync_r, txd_r, txd_nxt;
  // links to the shifters
  logic tx_ready, tx_line, tx_start;
  logic rx_done, rx_perr, rx_ferr;
  logic [7:0] rx_data;
  logic req, wr_take, rd_take, dlab;
  logic [7:0] rd_byte;

  uflc_fmt_if fmt();

  // format fields fan out straight from the register
  assign fmt.wlen = lfc_r[LFC_WL_HI:LFC_WL_LO];
  assign fmt.stop_sel = lfc_r[LFC_STOP];
  assign fmt.par_en = lfc_r[LFC_PEN];
  assign fmt.even_sel = lfc_r[LFC_EVEN];
  assign fmt.stick = lfc_r[LFC_STICK];
  assign fmt.tick = tick_r;

  assign dlab = lfc_r[LFC_DLAB];
  assign req = wb_cyc_i && wb_stb_i;
  // writes and read side effects act on the edge that the master sees ack
  assign wr_take = req && ack_r && wb_we_i && wb_sel_i[0];
  assign rd_take = req && ack_r && !wb_we_i;
  // a held byte is handed over once the shifter is idle
  assign tx_start = thr_full_r && tx_ready;

  // read mux, hidden registers read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr_i)
      OFS_DATA: rd_byte = dlab ? div_r[7:0] : rbr_r;
      OFS_DIV_HI: rd_byte = dlab ? div_r[15:8] : 8'h00;
      OFS_EFR: rd_byte = dlab ? efr_r : 8'h00;
      OFS_LFC: rd_byte = lfc_r;
      OFS_STAT: begin
        rd_byte[ST_RX_RDY] = rx_rdy_r;
        rd_byte[ST_THR_EMPTY] = !thr_full_r;
        rd_byte[ST_TX_IDLE] = tx_ready && !thr_full_r;
        rd_byte[ST_PERR] = perr_r;
        rd_byte[ST_FERR] = ferr_r;
      end
      default: rd_byte = 8'h00; // unmapped offsets answer zero
    endcase
  end

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_nxt = req && !ack_r;
    dat_nxt = ack_nxt ? {24'h000000, rd_byte} : dat_r;
  end

  // bus registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // register file next values
  always_comb begin
    lfc_nxt = lfc_r;
    div_nxt = div_r;
    efr_nxt = efr_r;
    thr_nxt = thr_r;
    thr_full_nxt = thr_full_r && !tx_start;
    rbr_nxt = rbr_r;
    rx_rdy_nxt = rx_rdy_r;
    perr_nxt = perr_r;
    ferr_nxt = ferr_r;
    // software clears first, hardware sets afterwards so a new event wins
    if (rd_take && wb_adr_i == OFS_DATA && !dlab) rx_rdy_nxt = 1'b0;
    if (rd_take && wb_adr_i == OFS_STAT) begin
      perr_nxt = 1'b0;
      ferr_nxt = 1'b0;
    end
    if (wr_take) begin
      unique case (wb_adr_i)
        OFS_DATA: begin
          if (dlab) begin
            div_nxt[7:0] = wb_dat_i[7:0];
          end else if (!thr_full_r || tx_start) begin
            thr_nxt = wb_dat_i[7:0];
            thr_full_nxt = 1'b1;
          end
        end
        OFS_DIV_HI: if (dlab) div_nxt[15:8] = wb_dat_i[7:0];
        OFS_EFR: if (dlab) efr_nxt = wb_dat_i[7:0];
        OFS_LFC: lfc_nxt = wb_dat_i[7:0];
        default: lfc_nxt = lfc_r; // writes elsewhere are dropped
      endcase
    end
    if (rx_done) begin
      rbr_nxt = rx_data;
      rx_rdy_nxt = 1'b1;
      perr_nxt = perr_r && !(rd_take && wb_adr_i == OFS_STAT) || rx_perr;
      ferr_nxt = ferr_r && !(rd_take && wb_adr_i == OFS_STAT) || rx_ferr;
    end
  end

  // register file flops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lfc_r <= LFC_RST;
      div_r <= DIV_RST;
      efr_r <= EFR_RST;
      thr_r <= 8'h00;
      thr_full_r <= 1'b0;
      rbr_r <= 8'h00;
      {rx_rdy_r, perr_r, ferr_r} <= 3'h0;
    end else begin
      lfc_r <= lfc_nxt;
      div_r <= div_nxt;
      efr_r <= efr_nxt;
      thr_r <= thr_nxt;
      thr_full_r <= thr_full_nxt;
      rbr_r <= rbr_nxt;
      {rx_rdy_r, perr_r, ferr_r} <= {rx_rdy_nxt, perr_nxt, ferr_nxt};
    end
  end

  // 16x tick divider; divisor zero behaves as one
  always_comb begin
    tick_nxt = (tcnt_r + 16'h0001 >= div_r);
    tcnt_nxt = tick_nxt ? 16'h0000 : tcnt_r + 16'h0001;
  end

  // divider flops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // break overrides whatever the shifter drives
  always_comb begin
    txd_nxt = lfc_r[LFC_BRK] ? 1'b0 : tx_line;
  end

  // line flops: two-stage input synchroniser and registered output
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      txd_r <= 1'b1;
    end else begin
      rx_meta_r <= serial_rx_i;
      rx_sync_r <= rx_meta_r;
      txd_r <= txd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign serial_tx_o = txd_r;

  uflc_tx u_tx (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .fmt(fmt.sh),
    .start_i(tx_start),
    .data_i(thr_r),
    .ready_o(tx_ready),
    .line_o(tx_line)
  );

  uflc_rx u_rx (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .fmt(fmt.sh),
    .rxd_i(rx_sync_r),
    .done_o(rx_done),
    .data_o(rx_data),
    .perr_o(rx_perr),
    .ferr_o(rx_ferr)
  );

  // a read request to a hidden register, answered next cycle
  sequence s_hidden_rd(logic [7:0] ofs);
    req && !wb_we_i && !ack_r && wb_adr_i == ofs && !dlab;
  endsequence
  property p_div_hidden;
    @(posedge core_clk_i) disable iff (sys_rst_i) s_hidden_rd(OFS_DIV_HI) |=> wb_ack_o && wb_dat_o == 32'h00000000;
  endproperty
  a_div_hidden: assert property (p_div_hidden) else $error("divisor visible without select");
  property p_efr_hidden;
    @(posedge core_clk_i) disable iff (sys_rst_i) s_hidden_rd(OFS_EFR) |=> wb_ack_o && wb_dat_o == 32'h00000000;
  endproperty
  a_efr_hidden: assert property (p_efr_hidden) else $error("enhanced byte visible without select");
  property p_div_wr_blocked;
    @(posedge core_clk_i) disable iff (sys_rst_i) wr_take && wb_adr_i == OFS_DIV_HI && !dlab |=> $stable(div_r);
  endproperty
  a_div_wr_blocked: assert property (p_div_wr_blocked) else $error("divisor written without select");
  property p_break_low;
    @(posedge core_clk_i) disable iff (sys_rst_i) lfc_r[LFC_BRK] ##1 lfc_r[LFC_BRK] |-> !serial_tx_o;
  endproperty
  a_break_low: assert property (p_break_low) else $error("serial output high during break");
  property p_stop_release;
    @(posedge core_clk_i) disable iff (sys_rst_i) $fell(lfc_r[LFC_BRK]) |-> ##1 serial_tx_o == $past(tx_line);
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("break not released");
  property p_lfc_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      wr_take && wb_adr_i == OFS_LFC |=> lfc_r == $past(wb_dat_i[7:0]) && fmt.wlen == lfc_r[1:0];
  endproperty
  a_lfc_write: assert property (p_lfc_write) else $error("format register not updated");
endmodule // uflc_top

// [uflc_remote_rx.sv]
// behavioural remote receiver that watches the transmit line
`timescale 1ns/1ps
module uflc_remote_rx (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic [5:0] fmt_i, // format the far side is set up for
  output logic done_o, // one-cycle pulse per character
  output logic [7:0] data_o,
  output logic par_o,
  output logic stop_o,
  output logic [7:0] gap_o // cycles from last stop sample to this start
);
  logic [7:0] d;
  logic p;
  int i;
  int g;
  // one character per pass; divisor is one, so a bit is 16 clocks
  initial begin
    done_o = 1'b0;
    data_o = 8'h00;
    par_o = 1'b0;
    stop_o = 1'b0;
    gap_o = 8'h00;
    g = 0;
    forever begin
      @(posedge clk_i);
      done_o <= 1'b0;
      if (g < 255) g++;
      if (line_i === 1'b0) begin
        repeat (8) @(posedge clk_i);
        // a glitch shorter than half a bit is no start
        if (line_i === 1'b0) begin
          gap_o <= 8'(g);
          d = 8'h00;
          p = 1'b0;
          for (i = 0; i < 5 + fmt_i[1:0]; i++) begin
            repeat (16) @(posedge clk_i);
            d[i] = line_i;
          end
          if (fmt_i[3]) begin
            repeat (16) @(posedge clk_i);
            p = line_i;
          end
          repeat (16) @(posedge clk_i);
          data_o <= d;
          par_o <= p;
          stop_o <= line_i;
          done_o <= 1'b1;
          g = 0;
          // a held break must end before the next start is hunted
          while (line_i !== 1'b1) begin
            @(posedge clk_i);
            done_o <= 1'b0;
          end
        end
      end
    end
  end
endmodule // uflc_remote_rx

// [uart_line_format_control_test.sv]
// self-checking bench: wishbone master, looped-back line, remote receiver
`timescale 1ns/1ps
module uart_line_format_control_test import uflc_pkg::*;;
  localparam logic [31:0] ALL_M = 32'hffffffff;
  logic core_clk;
  logic sys_rst;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic serial_tx;
  logic [5:0] far_fmt; // format given to the remote receiver
  logic p_done;
  logic [7:0] p_data;
  logic p_par;
  logic p_stop;
  logic [7:0] p_gap;
  int num_errors;
  int check_count;
  int frames;
  int k;
  logic [5:0] f;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [63:0] rq[$]; // read notes: mask and expected value
  logic [12:0] sq[$]; // character notes: gap flag, gap code, stop, parity, data
  logic [63:0] rn;
  logic [12:0] sn;

  // rx is fed from tx so the receive side sees real characters
  uflc_top uflc_top_i (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .serial_rx_i(serial_tx), .serial_tx_o(serial_tx));
  uflc_remote_rx uflc_remote_rx_i (.clk_i(core_clk), .line_i(serial_tx), .fmt_i(far_fmt), .done_o(p_done),
    .data_o(p_data), .par_o(p_par), .stop_o(p_stop), .gap_o(p_gap));

  // 200 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // own model of the character: data kept to the programmed length
  function automatic logic [7:0] emask(input logic [7:0] d, input logic [1:0] wl);
    return d & ~(8'hff << (5 + wl));
  endfunction

  function automatic logic epar(input logic [7:0] d, input logic [5:0] fm);
    if (fm[5]) return ~fm[4];
    return fm[4] ? ^emask(d, fm[1:0]) : ~^emask(d, fm[1:0]);
  endfunction

  // gap code is stop length in half-bits minus the half-bit before the sample
  function automatic logic [12:0] note(input logic [7:0] d, input logic [5:0] fm, input logic g);
    logic [1:0] gc;
    gc = !fm[2] ? 2'd1 : (fm[1:0] == 2'b00 ? 2'd2 : 2'd3);
    return {g, gc, 1'b1, fm[3] & epar(d, fm), emask(d, fm[1:0])};
  endfunction

  // classic single cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    if (!w) rq.push_back({m, d});
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'h1;
    wb_dat_w <= w ? {24'($urandom), d[7:0]} : 32'($urandom);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wait_frames(input int c);
    int t;
    t = 0;
    while (frames < c && t < 2000) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 2000) num_errors++;
    frames = 0;
  endtask

  // read data checked at the ack edge against the oldest note
  always @(posedge core_clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      rn = rq.pop_front();
      check(wb_dat_r & rn[63:32], rn[31:0] & rn[63:32]);
    end
  end

  // characters seen by the remote receiver
  always @(posedge core_clk) begin
    if (p_done === 1'b1) begin
      sn = sq.pop_front();
      check({22'h0, p_stop, p_par, p_data}, {22'h0, sn[9:0]});
      if (sn[12]) check(32'((p_gap + 4) / 8), {30'h0, sn[11:10]});
      frames++;
    end
  end

  // hang guard, well beyond the expected run
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    far_fmt = 6'h00;
    num_errors = 0;
    check_count = 0;
    frames = 0;
    void'($urandom(32'h7d78));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset values, hidden divisor and enhanced byte, unmapped place
    bus(0, OFS_LFC, {24'h0, LFC_RST}, ALL_M);
    bus(0, OFS_STAT, 32'h06, 32'h1f);
    bus(1, OFS_DIV_HI, 32'h55, 0);
    bus(0, OFS_DIV_HI, 32'h0, ALL_M);
    bus(0, OFS_EFR, 32'h0, ALL_M);
    bus(1, OFS_LFC, 32'h83, 0);
    bus(0, OFS_DIV_HI, {24'h0, DIV_RST[15:8]}, ALL_M);
    bus(0, OFS_DATA, {24'h0, DIV_RST[7:0]}, ALL_M);
    bus(1, OFS_EFR, 32'h5a, 0);
    bus(0, OFS_EFR, {24'h0, 8'h5a}, ALL_M);
    bus(1, OFS_DATA, {24'h0, DIV_RST[7:0]}, 0); // divisor write, no character may leave
    bus(1, OFS_LFC, 32'h03, 0);
    bus(0, OFS_EFR, 32'h0, ALL_M);
    bus(0, 8'h20, 32'h0, ALL_M);
    bus(1, 8'h20, 32'hff, 0);
    bus(0, OFS_LFC, 32'h03, ALL_M);
    // every format, two characters back to back
    for (k = 0; k < 64; k++) begin
      f = 6'(k);
      bus(1, OFS_LFC, {26'h0, f}, 0);
      far_fmt <= f;
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      sq.push_back(note(b0, f, 1'b0));
      bus(1, OFS_DATA, {24'h0, b0}, 0);
      repeat (30) @(posedge core_clk);
      sq.push_back(note(b1, f, 1'b1));
      bus(1, OFS_DATA, {24'h0, b1}, 0);
      wait_frames(2);
      repeat (40) @(posedge core_clk);
      bus(0, OFS_LFC, {26'h0, f}, ALL_M);
      bus(0, OFS_STAT, 32'h01, 32'h19);
      bus(0, OFS_DATA, {24'h0, emask(b1, f[1:0])}, ALL_M);
    end
    // sent odd, receiver switched to even mid character
    f = 6'h0b;
    bus(1, OFS_LFC, {26'h0, f}, 0);
    far_fmt <= f;
    b0 = 8'($urandom);
    sq.push_back(note(b0, f, 1'b0));
    bus(1, OFS_DATA, {24'h0, b0}, 0);
    repeat (40) @(posedge core_clk);
    bus(1, OFS_LFC, 32'h1b, 0);
    wait_frames(1);
    repeat (40) @(posedge core_clk);
    bus(0, OFS_STAT, 32'h08, 32'h08);
    bus(0, OFS_STAT, 32'h00, 32'h18);
    bus(0, OFS_DATA, 32'h0, 32'h0);
    // break held past a whole character, then released
    bus(1, OFS_LFC, 32'h43, 0);
    far_fmt <= 6'h03;
    sq.push_back(13'h0000);
    repeat (4) @(posedge core_clk);
    check({31'h0, serial_tx}, 32'h0);
    wait_frames(1);
    check({31'h0, serial_tx}, 32'h0);
    bus(1, OFS_LFC, 32'h03, 0);
    repeat (4) @(posedge core_clk);
    check({31'h0, serial_tx}, 32'h1);
    repeat (400) @(posedge core_clk);
    bus(0, OFS_STAT, 32'h10, 32'h10);
    bus(0, OFS_STAT, 32'h00, 32'h18);
    bus(0, OFS_DATA, 32'h0, 32'h0);
    report_and_stop();
  end
endmodule // uart_line_format_control_test
